// [hdl/pfce_host.sv]
// Purpose: Host controller driving a x16 parallel NOR flash over its pins.
// Assumes: Flash inputs sampled synchronously to pclk; APB slave access.
// Notes: One command per GO; program and erase status polled on toggle bit until done.
//
// The implementer's own choices: the APB slave port and the placing of the registers.
`default_nettype none
module pfce_host
  import pfce_pkg::*;
#(
  parameter int SUSP_WAIT_CYC = pfce_pkg::PFCE_SUSP_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic flash_sel_n,
  output logic flash_oe_n,
  output logic flash_we_n,
  output logic flash_wp_n,
  output logic [21:0] flash_addr,
  output logic [15:0] flash_dq_o,
  output logic flash_dq_oe,
  input wire logic [15:0] flash_dq_i
);
  import pfce_pkg::*;

  typedef enum logic [5:0] {
    PFCE_IDLE = 6'h01,
    PFCE_WSET = 6'h02,
    PFCE_WLOW = 6'h04,
    PFCE_RSET = 6'h08,
    PFCE_RGAP = 6'h10,
    PFCE_WAIT = 6'h20
  } pfce_state_e;

  pfce_state_e state_ff;
  logic [31:0] ctrl_ff;
  logic [21:0] addr_ff;
  logic [15:0] wdata_ff;
  logic [15:0] rdata_ff;
  logic busy_ff;
  logic err_ff;
  logic susp_ff;
  logic [2:0] step_ff;
  logic [3:0] cnt_ff;
  logic [31:0] wait_ff;
  logic first_ff;
  logic [15:0] prev_ff;
  logic [2:0] op;
  logic [2:0] last_step;
  logic [21:0] cyc_addr;
  logic [15:0] cyc_data;
  logic apb_wr;
  logic go;

  assign op = ctrl_ff[PFCE_CTRL_OP_LSB +: 3];
  assign apb_wr = psel & penable & pwrite;
  assign go = apb_wr && (paddr == PFCE_CTRL_OFF) &&
              pwdata[PFCE_CTRL_GO_BIT] && !busy_ff;

  // ---------------------------------------------------------------
  // APB slave: zero wait states, error on any address above the RDATA offset
  // ---------------------------------------------------------------
  assign pready = 1'b1;
  assign pslverr = psel & penable & (paddr > PFCE_RDATA_OFF);

  // Register writes; config ignored while busy so a sequence stays stable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= 32'h0000_0100;
      addr_ff <= 22'h000000;
      wdata_ff <= 16'h0000;
    end else if (apb_wr && !busy_ff) begin
      unique case (paddr)
        PFCE_CTRL_OFF: ctrl_ff <= pwdata; // WP level held here
        PFCE_ADDR_OFF: addr_ff <= pwdata[21:0];
        PFCE_WDATA_OFF: wdata_ff <= pwdata[15:0];
        default: ;
      endcase
    end
  end

  // Read mux
  always_comb begin
    unique case (paddr)
      PFCE_CTRL_OFF: prdata = ctrl_ff;
      PFCE_ADDR_OFF: prdata = {10'h000, addr_ff};
      PFCE_WDATA_OFF: prdata = {16'h0000, wdata_ff};
      PFCE_STAT_OFF: prdata = {29'h0, susp_ff, err_ff, busy_ff};
      PFCE_RDATA_OFF: prdata = {16'h0000, rdata_ff};
      default: prdata = 32'h0000_0000;
    endcase
  end

  // ---------------------------------------------------------------
  // Command sequence table: address/data of each write cycle
  // ---------------------------------------------------------------
  always_comb begin
    cyc_addr = PFCE_UNLOCK_A1;
    cyc_data = PFCE_CMD_AA;
    last_step = 3'h0;
    unique case (op)
      PFCE_OP_PROG: last_step = 3'h3; // Unlock then word
      PFCE_OP_SECT, PFCE_OP_BLK: last_step = 3'h5;
      default: last_step = 3'h0; // Single cycle
    endcase
    unique case (step_ff)
      3'h1, 3'h4: begin
        cyc_addr = PFCE_UNLOCK_A2;
        cyc_data = PFCE_CMD_55;
      end
      3'h2: cyc_data = (op == PFCE_OP_PROG) ? PFCE_CMD_PROG : PFCE_CMD_ERASE;
      3'h3: begin
        cyc_addr = (op == PFCE_OP_PROG) ? addr_ff : PFCE_UNLOCK_A1;
        cyc_data = (op == PFCE_OP_PROG) ? wdata_ff : PFCE_CMD_AA;
      end
      3'h5: begin
        cyc_addr = addr_ff; // Sector/block base address
        cyc_data = (op == PFCE_OP_BLK) ? PFCE_CMD_BLK : PFCE_CMD_SECT;
      end
      default: ;
    endcase
    if (op == PFCE_OP_SUSP) begin
      cyc_data = PFCE_CMD_SUSP;
    end else if (op == PFCE_OP_RESUME) begin
      cyc_addr = addr_ff; // Any address works
      cyc_data = PFCE_CMD_RESUME;
    end
  end

  // ---------------------------------------------------------------
  // Bus cycle sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= PFCE_IDLE;
      step_ff <= 3'h0;
      cnt_ff <= 4'h0;
      wait_ff <= 32'h0;
      first_ff <= 1'b0;
      prev_ff <= 16'h0000;
      rdata_ff <= 16'h0000;
      busy_ff <= 1'b0;
      err_ff <= 1'b0;
      susp_ff <= 1'b0;
      flash_sel_n <= 1'b1;
      flash_oe_n <= 1'b1;
      flash_we_n <= 1'b1;
      flash_addr <= 22'h000000;
      flash_dq_o <= 16'h0000;
      flash_dq_oe <= 1'b0;
    end else begin
      cnt_ff <= cnt_ff + 4'h1;
      unique case (state_ff)
        PFCE_IDLE: begin
          flash_sel_n <= 1'b1; // Deselect between accesses
          if (go) begin
            busy_ff <= 1'b1;
            err_ff <= 1'b0;
            step_ff <= 3'h0;
            cnt_ff <= 4'h0;
            flash_sel_n <= 1'b0;
            if (pwdata[PFCE_CTRL_OP_LSB +: 3] == 3'(PFCE_OP_READ)) begin
              flash_addr <= addr_ff; // New address wakes device
              flash_oe_n <= 1'b0;
              state_ff <= PFCE_RSET;
            end else begin
              state_ff <= PFCE_WSET;
            end
          end
        end
        PFCE_WSET: begin
          // Address and data stand a cycle before strobe falls, so the
          // device never latches an address that is still moving
          flash_addr <= cyc_addr;
          flash_dq_o <= cyc_data;
          flash_dq_oe <= 1'b1;
          cnt_ff <= 4'h0;
          if (flash_dq_oe && (flash_addr == cyc_addr) &&
              (flash_dq_o == cyc_data)) begin
            flash_we_n <= 1'b0; // Strobe with select low
            state_ff <= PFCE_WLOW;
          end
        end
        PFCE_WLOW: begin
          if (cnt_ff == PFCE_STROBE_CYC) begin
            flash_we_n <= 1'b1; // Data latched on this edge
            cnt_ff <= 4'h0;
            if (step_ff == last_step) begin
              first_ff <= 1'b1;
              wait_ff <= 32'h0;
              state_ff <= PFCE_WAIT; // Internal op starts
            end else begin
              step_ff <= step_ff + 3'h1;
              state_ff <= PFCE_WSET;
            end
          end
        end
        PFCE_RSET: begin
          if (cnt_ff == PFCE_ACCESS_CYC) begin
            rdata_ff <= flash_dq_i;
            flash_oe_n <= 1'b1;
            flash_sel_n <= 1'b1;
            busy_ff <= 1'b0;
            state_ff <= PFCE_IDLE;
          end
        end
        PFCE_WAIT: begin
          // Status poll loop; no new command issued meanwhile
          flash_dq_oe <= 1'b0;
          wait_ff <= wait_ff + 32'h1;
          if (op == PFCE_OP_SUSP || op == PFCE_OP_RESUME) begin
            if (op == PFCE_OP_RESUME || wait_ff >= SUSP_WAIT_CYC) begin
              susp_ff <= (op == PFCE_OP_SUSP);
              busy_ff <= 1'b0;
              state_ff <= PFCE_IDLE;
            end
          end else begin
            flash_oe_n <= 1'b0; // Only status reads now
            cnt_ff <= 4'h0;
            state_ff <= PFCE_RGAP;
          end
        end
        PFCE_RGAP: begin
          if (cnt_ff == PFCE_ACCESS_CYC) begin
            flash_oe_n <= 1'b1;
            prev_ff <= flash_dq_i;
            first_ff <= 1'b0;
            rdata_ff <= flash_dq_i;
            // Toggle stopped means done; device back in read
            if (!first_ff && (prev_ff[6] == flash_dq_i[6])) begin
              busy_ff <= 1'b0;
              // Protected-block erase is dropped by device: no toggle
              err_ff <= (op == PFCE_OP_PROG) &&
                        (flash_dq_i != wdata_ff);
              state_ff <= PFCE_IDLE;
            end else begin
              state_ff <= PFCE_WAIT;
            end
          end
        end
        default: state_ff <= PFCE_IDLE;
      endcase
    end
  end

  // Write-protect pin follows CTRL, stable because CTRL locks when busy
  assign flash_wp_n = ctrl_ff[PFCE_CTRL_WPN_BIT];
endmodule : pfce_host
`default_nettype wire

// [pkg/pfce_pkg.sv]
// Purpose: Constants for the parallel flash command engine (host side).
// Assumes: 125 MHz pclk; APB register access to the engine.
// Notes: Device command codes and unlock addresses kept here once.
`default_nettype none
package pfce_pkg;
  // ---------------------------------------------------------------
  // Register map (byte offsets)
  // ---------------------------------------------------------------
  localparam logic [7:0] PFCE_CTRL_OFF = 8'h00;
  localparam logic [7:0] PFCE_ADDR_OFF = 8'h04;
  localparam logic [7:0] PFCE_WDATA_OFF = 8'h08;
  localparam logic [7:0] PFCE_STAT_OFF = 8'h0C;
  localparam logic [7:0] PFCE_RDATA_OFF = 8'h10;
  // CTRL field positions
  localparam int PFCE_CTRL_GO_BIT = 0;
  localparam int PFCE_CTRL_OP_LSB = 4;
  localparam int PFCE_CTRL_WPN_BIT = 8;
  localparam logic PFCE_WPN_RESET = 1'b1;
  // STAT field positions
  localparam int PFCE_STAT_BUSY_BIT = 0;
  localparam int PFCE_STAT_ERR_BIT = 1;
  localparam int PFCE_STAT_SUSP_BIT = 2;
  // ---------------------------------------------------------------
  // Operation codes written to CTRL.op
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    PFCE_OP_READ = 3'h0,
    PFCE_OP_PROG = 3'h1,
    PFCE_OP_SECT = 3'h2,
    PFCE_OP_BLK = 3'h3,
    PFCE_OP_SUSP = 3'h4,
    PFCE_OP_RESUME = 3'h5
  } pfce_op_e;
  // ---------------------------------------------------------------
  // Device command codes and unlock addresses
  // ---------------------------------------------------------------
  localparam logic [15:0] PFCE_CMD_AA = 16'h00AA;
  localparam logic [15:0] PFCE_CMD_55 = 16'h0055;
  localparam logic [15:0] PFCE_CMD_PROG = 16'h00A0;
  localparam logic [15:0] PFCE_CMD_ERASE = 16'h0080;
  localparam logic [15:0] PFCE_CMD_SECT = 16'h0030;
  localparam logic [15:0] PFCE_CMD_BLK = 16'h0050;
  localparam logic [15:0] PFCE_CMD_SUSP = 16'h00B0;
  localparam logic [15:0] PFCE_CMD_RESUME = 16'h0030;
  localparam logic [21:0] PFCE_UNLOCK_A1 = 22'h005555;
  localparam logic [21:0] PFCE_UNLOCK_A2 = 22'h002AAA;
  // ---------------------------------------------------------------
  // Bus cycle timing
  // ---------------------------------------------------------------
  localparam int PFCE_CLK_MHZ = 125;
  localparam int PFCE_T_STROBE_NS = 40;
  localparam int PFCE_T_ACCESS_NS = 70;
  localparam int PFCE_T_PROG_US = 10;
  localparam int PFCE_T_SUSP_US = 20;
  localparam logic [3:0] PFCE_STROBE_CYC =
    4'((PFCE_T_STROBE_NS * PFCE_CLK_MHZ + 999) / 1000);
  localparam logic [3:0] PFCE_ACCESS_CYC =
    4'((PFCE_T_ACCESS_NS * PFCE_CLK_MHZ + 999) / 1000);
  localparam int PFCE_PROG_CYC = PFCE_T_PROG_US * PFCE_CLK_MHZ;
  localparam int PFCE_SUSP_CYC = PFCE_T_SUSP_US * PFCE_CLK_MHZ;
endpackage : pfce_pkg
`default_nettype wire

// [tb/pfce_flash_model.sv]
// Purpose: Behavioural x16 NOR flash on the far side of the host.
// Assumes: Bottom boot block; short internal times for simulation.
// Notes: Deselected bus shows the inverse of the last read word.
`default_nettype none
module pfce_flash_model #(
  parameter int T_PROG_NS = 2000,
  parameter int T_ERASE_NS = 6000
) (
  input wire logic sel_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic wp_n,
  input wire logic [21:0] addr,
  input wire logic [15:0] dq_in,
  output logic [15:0] dq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [int];
  logic [21:0] la, eb = '0, esz = 22'h800;
  logic [15:0] ld, pv = '0, rd = '0;
  logic er = 1'b0, susp = 1'b0, tgl = 1'b0;
  int step = 0;
  realtime done_t = 0, rem = 0;
  function automatic logic [15:0] rdm(input logic [21:0] a);
    return mem.exists(a) ? mem[a] : 16'hFFFF;
  endfunction : rdm
  function automatic logic in_sus(input logic [21:0] a);
    return susp && ((a & ~(esz - 22'h1)) == eb);
  endfunction : in_sus
  // Pins follow while strobe low; last value at rise wins
  always @(we_n, addr, dq_in) if (!we_n) begin
    la = addr;
    ld = dq_in;
  end
  // Command state on strobe rise; bad cycle returns to read
  always @(posedge we_n) begin
    if ($realtime < done_t) begin
      if (er && ld[7:0] == 8'hB0) begin
        rem = done_t - $realtime;
        done_t = 0;
        susp = 1'b1;
      end
    end else if (susp && step == 0 && ld[7:0] == 8'h30) begin
      done_t = $realtime + rem;
      susp = 1'b0;
      er = 1'b1;
    end else case (step)
      0, 3: step = (la == 22'h5555 && ld[7:0] == 8'hAA) ? step + 1 : 0;
      1, 4: step = (la == 22'h2AAA && ld[7:0] == 8'h55) ? step + 1 : 0;
      2: step = la != 22'h5555 ? 0 : ld[7:0] == 8'hA0 ? 6 :
        ld[7:0] == 8'h80 ? 3 : 0;
      6: begin
        step = 0;
        if (!in_sus(la)) begin
          mem[la] = rdm(la) & ld;
          pv = ld;
          er = 1'b0;
          done_t = $realtime + T_PROG_NS;
        end
      end
      default: begin
        step = 0;
        esz = ld[7:0] == 8'h30 ? 22'h800 : 22'h8000;
        eb = la & ~(esz - 22'h1);
        if ((ld[7:0] == 8'h30 || ld[7:0] == 8'h50) && !susp &&
            (wp_n || eb >= 22'h8000)) begin
          for (int i = 0; i < esz; i++) mem.delete(eb + 22'(i));
          er = 1'b1;
          done_t = $realtime + T_ERASE_NS;
        end
      end
    endcase
  end
  // Each read: status while busy or inside the suspended sector or block, else array data
  always @(negedge oe_n) begin
    #5;
    tgl = ~tgl;
    if ($realtime < done_t)
      rd = er ? {9'h0, tgl, 3'h0, tgl, 2'h0} : {8'h0, ~pv[7], tgl, 6'h0};
    else if (in_sus(addr))
      rd = {8'h0, 2'b11, 3'h0, tgl, 2'h0};
    else
      rd = rdm(addr);
  end
  assign dq = (!sel_n && !oe_n) ? rd : ~rd;
endmodule : pfce_flash_model
`default_nettype wire

// [tb/pfce_host_asserts.sv]
// Purpose: Pin-level checks on the flash host controller.
// Assumes: One clock domain; all flash pins registered on pclk.
// Notes: Bound into pfce_host below.
`default_nettype none
module pfce_host_asserts (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic flash_sel_n,
  input wire logic flash_oe_n,
  input wire logic flash_we_n,
  input wire logic flash_wp_n,
  input wire logic [21:0] flash_addr,
  input wire logic [15:0] flash_dq_o,
  input wire logic flash_dq_oe,
  input wire logic [15:0] flash_dq_i
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_we_sel: assert property (!flash_we_n |-> !flash_sel_n)
    else $error("Strobe without select");
  chk_we_oe_excl: assert property (!flash_we_n |-> flash_oe_n)
    else $error("Strobe during output enable");
  chk_no_fight: assert property (!flash_oe_n |-> !flash_dq_oe)
    else $error("Host drives bus during read");
  chk_read_sel: assert property (!flash_oe_n |-> !flash_sel_n)
    else $error("Read without select");
  chk_we_drives: assert property (!flash_we_n |-> flash_dq_oe)
    else $error("Write data not driven");
  chk_addr_setup: assert property ($fell(flash_we_n)
    |-> $stable(flash_addr) && $stable(flash_dq_o))
    else $error("Address or data moved as strobe fell");
  chk_addr_hold: assert property (!flash_we_n && !$past(flash_we_n)
    |-> $stable(flash_addr) && $stable(flash_dq_o))
    else $error("Address or data moved in strobe");
  chk_strobe_len: assert property ($fell(flash_we_n)
    |-> !flash_we_n [*6] ##1 flash_we_n)
    else $error("Strobe width wrong");
  chk_wp_steady: assert property (!flash_we_n |-> $stable(flash_wp_n))
    else $error("Write protect moved in strobe");
endmodule : pfce_host_asserts

bind pfce_host pfce_host_asserts pfce_host_asserts_i (.pclk, .presetn,
  .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .flash_sel_n, .flash_oe_n, .flash_we_n, .flash_wp_n, .flash_addr,
  .flash_dq_o, .flash_dq_oe, .flash_dq_i);
`default_nettype wire

// [tb/pfce_host_tb.sv]
// Purpose: Self-checking bench for the flash host controller.
// Assumes: Suspend wait shortened to 20 cycles.
// Notes: Random words and addresses from a fixed seed.
`default_nettype none
module pfce_host_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import pfce_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, q;
  logic pready, pslverr, serr, sel_n, oe_n, we_n, wp_n, dq_oe;
  logic [21:0] faddr, a, b;
  logic [15:0] dq_o, dq_dev, dq_bus, w, v;
  int n_fail = 0, n_compared = 0;
  assign dq_bus = dq_oe ? dq_o : dq_dev;
  pfce_host #(.SUSP_WAIT_CYC(20)) pfce_host_i (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .flash_sel_n(sel_n), .flash_oe_n(oe_n), .flash_we_n(we_n),
    .flash_wp_n(wp_n), .flash_addr(faddr), .flash_dq_o(dq_o),
    .flash_dq_oe(dq_oe), .flash_dq_i(dq_bus));
  pfce_flash_model pfce_flash_model_i (.sel_n, .oe_n, .we_n, .wp_n,
    .addr(faddr), .dq_in(dq_bus), .dq(dq_dev));
  initial forever #4 pclk = ~pclk;
  function automatic logic [31:0] exp_st(input logic [15:0] o, n);
    return {30'h0, (o & n) !== n, 1'b0};
  endfunction : exp_st
  task automatic report_and_stop();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [31:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] ad, input [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic run(input logic [2:0] op, input logic [21:0] ad,
      input logic [15:0] d, input logic wp);
    int n;
    apb(1'b1, PFCE_ADDR_OFF, {10'h0, ad});
    apb(1'b1, PFCE_WDATA_OFF, {16'h0, d});
    apb(1'b1, PFCE_CTRL_OFF, {23'h0, wp, 1'b0, op, 4'h1});
    n = 0;
    do begin
      apb(1'b0, PFCE_STAT_OFF, 32'h0);
      n++;
    end while (q[0] !== 1'b0 && n < 3000);
    if (n >= 3000) begin
      n_fail++;
      $display("[ERR] %0t status poll timed out", $time);
    end
  endtask : run
  task automatic rdw(input logic [21:0] ad, input logic [15:0] e);
    run(PFCE_OP_READ, ad, 16'h0, 1'b1);
    apb(1'b0, PFCE_RDATA_OFF, 32'h0);
    chk(q, {16'h0, e});
  endtask : rdw
  // Bounded run time
  initial begin
    #400000;
    n_fail++;
    $display("[ERR] %0t watchdog expired", $time);
    report_and_stop();
  end
  // Main sequence
  initial begin
    void'($urandom(72639));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk({27'h0, sel_n, oe_n, we_n, wp_n, dq_oe}, 32'h1E);
    apb(1'b0, PFCE_STAT_OFF, 32'h0);
    chk(q, 32'h0);
    apb(1'b0, 8'h14, 32'h0);
    chk({31'h0, serr}, 32'h1);
    for (int i = 0; i < 3; i++) begin
      a = 22'($urandom_range(32768, 4000000));
      b = (a | 22'h7FF) + 22'h1;
      w = 16'($urandom);
      v = 16'($urandom);
      run(PFCE_OP_PROG, a, w, 1'b1);
      chk(q, 32'h0);
      apb(1'b0, PFCE_ADDR_OFF, 32'h0);
      chk(q, {10'h0, a});
      rdw(a, w);
      run(PFCE_OP_PROG, a, v, 1'b1);
      chk(q, exp_st(w, v));
      run(PFCE_OP_PROG, b, w, 1'b1);
      run(PFCE_OP_SECT, a, 16'h0, 1'b1);
      rdw(a, 16'hFFFF);
      rdw(b, w);
      run(PFCE_OP_BLK, b, 16'h0, 1'b1);
      rdw(b, 16'hFFFF);
    end
    a = 22'($urandom_range(0, 32767));
    run(PFCE_OP_PROG, a, 16'h1234, 1'b1);
    run(PFCE_OP_BLK, a, 16'h0, 1'b0);
    rdw(a, 16'h1234);
    run(PFCE_OP_SECT, a, 16'h0, 1'b1);
    rdw(a, 16'hFFFF);
    run(PFCE_OP_SUSP, a, 16'h0, 1'b1);
    chk(q, 32'h4);
    run(PFCE_OP_RESUME, a, 16'h0, 1'b1);
    chk(q, 32'h0);
    report_and_stop();
  end
endmodule : pfce_host_tb
`default_nettype wire
